// >>> rtl/rsr_pkg.sv
// Purpose: constants and carriers for the radio status register bank
// Assumes: 8-bit register port, one clock, synchronous active-low reset
// Notes:   all registers read-only
//
// Overview of operation
// - Register 0x30 returns a fixed part identification byte.
// - Register 0x31 returns a fixed silicon revision byte.
// - Register 0x32 returns the signed carrier offset estimate, step crystal/2^14.
// - Carrier offset reads zero while amplitude or on-off keying is selected.
// - Bit 7 of 0x33 and 0x38 is checksum match, cleared on receive entry.
// - Bits 6:0 of 0x33 hold link quality over 64 symbols after sync.
// - Register 0x34 returns the received signal strength byte.
// - State field bits 4:0 encode sleep through calibration end as listed.
// - Codes 0x0d to 0x16 cover receive, transmit and switching; bits 7:5 zero.
// - Sleep and crystal-off codes are never seen, access wakes to idle.
// - Wake timer reads as high byte at 0x36, low byte at 0x37.
// - Register 0x38 bits 6..3 show carrier sense, preamble, clear, sync.
// - Bit 2 of 0x38 shows output two before inversion.
// - Bit 0 of 0x38 shows output zero before inversion; bit 1 zero.
// - Register 0x39 returns the oscillator control DAC setting, test only.
package rsr_pkg;
	localparam int          ADDR_W            = 6;
	localparam int          DATA_W            = 8;
	localparam logic [5:0]  ADDR_PART         = 6'h30;
	localparam logic [5:0]  ADDR_REV          = 6'h31;
	localparam logic [5:0]  ADDR_FREQ         = 6'h32;
	localparam logic [5:0]  ADDR_LQI          = 6'h33;
	localparam logic [5:0]  ADDR_SIGNAL       = 6'h34;
	localparam logic [5:0]  ADDR_STATE        = 6'h35;
	localparam logic [5:0]  ADDR_WAKE_HI      = 6'h36;
	localparam logic [5:0]  ADDR_WAKE_LO      = 6'h37;
	localparam logic [5:0]  ADDR_PKT          = 6'h38;
	localparam logic [5:0]  ADDR_DAC          = 6'h39;
	localparam logic [7:0]  RDATA_RESET       = 8'h00;
	localparam logic [7:0]  UNMAPPED_DATA     = 8'h00;
	localparam logic [7:0]  OFFSET_KEYED      = 8'h00;
	localparam logic [4:0]  STATE_SLEEP       = 5'h00;
	localparam logic [4:0]  STATE_IDLE        = 5'h01;
	localparam logic [4:0]  STATE_CRYSTAL_OFF_STATE_CODE   = 5'h02;
	localparam logic [4:0]  STATE_LAST        = 5'h16;
	localparam int          LQI_SYMBOLS       = 64;

	typedef struct packed {
		logic       carrier_sense;
		logic       preamble_quality_met;
		logic       channel_clear_flag;
		logic       sync_found_flag;
		logic       general_output_two;
		logic       general_output_zero;
	} rsr_pins_t;

	typedef struct packed {
		logic [7:0]  carrier_offset_estimate;
		logic [6:0]  link_quality_estimate;
		logic        crc_match;
		logic [7:0]  signal_strength;
		logic [4:0]  radio_state_field;
		logic [15:0] wake_timer;
		logic [7:0]  oscillator_dac_setting;
	} rsr_status_t;
endpackage : rsr_pkg

// >>> rtl/rsr_status_regs.sv
// Purpose: read-only status register bank of the radio
// Assumes: status inputs come from logic on clk_sys_i; read data one cycle later
// Notes:   general outputs arrive pre-inversion; access wakes radio first
//
// Decided for this implementation: the address-and-strobe port.
module rsr_status_regs #(
	parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] REV_ID  = 8'ha5  // Arbitrary value
) (
	input  wire logic                      clk_sys_i,
	input  wire logic                      rst_n_i,
	input  wire logic [rsr_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [rsr_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	input  wire logic                      amplitude_keying_i,
	input  wire rsr_pkg::rsr_status_t      status_i,
	input  wire rsr_pkg::rsr_pins_t        pins_i,
	output logic [rsr_pkg::DATA_W-1:0]     rdata_o
);
	import rsr_pkg::*;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [7:0] rdata_nxt;
	logic [7:0] state_view;

	// Access already woke the radio, so never show sleep or crystal off
	always_comb begin
		state_view = {3'h0, status_i.radio_state_field};
		if (status_i.radio_state_field == STATE_SLEEP ||
		    status_i.radio_state_field == STATE_CRYSTAL_OFF_STATE_CODE) begin
			state_view = {3'h0, STATE_IDLE};
		end
	end

	always_comb begin
		unique case (addr_i)
			ADDR_PART:    rdata_nxt = PART_ID;
			ADDR_REV:     rdata_nxt = REV_ID;
			ADDR_FREQ:    rdata_nxt = amplitude_keying_i ? OFFSET_KEYED : status_i.carrier_offset_estimate;
			ADDR_LQI:     rdata_nxt = {status_i.crc_match, status_i.link_quality_estimate};
			ADDR_SIGNAL:  rdata_nxt = status_i.signal_strength;
			ADDR_STATE:   rdata_nxt = state_view;
			ADDR_WAKE_HI: rdata_nxt = status_i.wake_timer[15:8];
			ADDR_WAKE_LO: rdata_nxt = status_i.wake_timer[7:0];
			ADDR_PKT:     rdata_nxt = {status_i.crc_match, pins_i.carrier_sense, pins_i.preamble_quality_met,
			                           pins_i.channel_clear_flag, pins_i.sync_found_flag,
			                           pins_i.general_output_two, 1'b0, pins_i.general_output_zero};
			ADDR_DAC:     rdata_nxt = status_i.oscillator_dac_setting;
			default:      rdata_nxt = UNMAPPED_DATA;
		endcase
	end

	// ------------------------------------------------------------
	// Read register
	// ------------------------------------------------------------
	// Writes are simply not decoded: nothing here stores them
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_o <= RDATA_RESET;
		end else if (rd_i) begin
			rdata_o <= rdata_nxt;
		end else begin
			rdata_o <= RDATA_RESET;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// One read strobe aimed at one register
	sequence read_of(logic [5:0] a);
		rd_i && addr_i == a;
	endsequence

	// Reset must clear the data even though the other checks are disabled then
	reset_value_a: assert property (disable iff (1'b0) !rst_n_i |=> rdata_o == RDATA_RESET)
		else $error("read data not cleared by reset");
	idle_data_zero_a: assert property (!rd_i |=> rdata_o == RDATA_RESET)
		else $error("read data stands without a read");
	unmapped_zero_a: assert property (rd_i && (addr_i < ADDR_PART || addr_i > ADDR_DAC)
		|=> rdata_o == UNMAPPED_DATA)
		else $error("unmapped read not zero");
	wake_low_read_a: assert property (read_of(ADDR_WAKE_LO) |=> rdata_o == $past(status_i.wake_timer[7:0]))
		else $error("wake low byte wrong");
	pkt_live_flags_a: assert property (read_of(ADDR_PKT)
		|=> rdata_o[5] == $past(pins_i.preamble_quality_met) && rdata_o[4] == $past(pins_i.channel_clear_flag)
		&& rdata_o[3] == $past(pins_i.sync_found_flag))
		else $error("packet flags wrong");
	state_idle_shown_a: assert property (read_of(ADDR_STATE)
		&& (status_i.radio_state_field == STATE_SLEEP || status_i.radio_state_field == STATE_CRYSTAL_OFF_STATE_CODE)
		|=> rdata_o == {3'h0, STATE_IDLE})
		else $error("hidden state not shown as idle");

	part_id_read_a: assert property (rd_i && addr_i == ADDR_PART |=> rdata_o == PART_ID)
		else $error("part id wrong");
	rev_id_read_a: assert property (rd_i && addr_i == ADDR_REV |=> rdata_o == REV_ID)
		else $error("revision id wrong");
	freq_ask_zero_a: assert property (rd_i && addr_i == ADDR_FREQ && amplitude_keying_i |=> rdata_o == 8'h00)
		else $error("offset not zero under keying");
	freq_fsk_value_a: assert property (rd_i && addr_i == ADDR_FREQ && !amplitude_keying_i
		|=> rdata_o == $past(status_i.carrier_offset_estimate))
		else $error("offset value wrong");
	crc_bits_agree_a: assert property (rd_i && (addr_i == ADDR_LQI || addr_i == ADDR_PKT)
		|=> rdata_o[7] == $past(status_i.crc_match))
		else $error("checksum flag wrong");
	lqi_value_a: assert property (rd_i && addr_i == ADDR_LQI |=> rdata_o[6:0] == $past(status_i.link_quality_estimate))
		else $error("link quality wrong");
	signal_read_a: assert property (rd_i && addr_i == ADDR_SIGNAL |=> rdata_o == $past(status_i.signal_strength))
		else $error("signal strength wrong");
	state_upper_zero_a: assert property (rd_i && addr_i == ADDR_STATE |=> rdata_o[7:5] == 3'h0)
		else $error("state upper bits set");
	state_no_sleep_a: assert property (rd_i && addr_i == ADDR_STATE
		|=> rdata_o != {3'h0, STATE_SLEEP} && rdata_o != {3'h0, STATE_CRYSTAL_OFF_STATE_CODE})
		else $error("sleep code visible");
	state_code_pass_a: assert property (rd_i && addr_i == ADDR_STATE && status_i.radio_state_field > STATE_CRYSTAL_OFF_STATE_CODE
		|=> rdata_o[4:0] == $past(status_i.radio_state_field))
		else $error("state code wrong");
	wake_bytes_a: assert property (rd_i && addr_i == ADDR_WAKE_HI |=> rdata_o == $past(status_i.wake_timer[15:8]))
		else $error("wake high byte wrong");
	pkt_bits_a: assert property (rd_i && addr_i == ADDR_PKT
		|=> rdata_o[1] == 1'b0 && rdata_o[2] == $past(pins_i.general_output_two)
		&& rdata_o[0] == $past(pins_i.general_output_zero) && rdata_o[6] == $past(pins_i.carrier_sense))
		else $error("packet status wrong");
	dac_read_a: assert property (rd_i && addr_i == ADDR_DAC |=> rdata_o == $past(status_i.oscillator_dac_setting))
		else $error("dac setting wrong");
	write_inert_a: assert property (wr_i |=> rdata_o == RDATA_RESET)
		else $error("write had effect");
endmodule : rsr_status_regs

// >>> dv/rsr_status_regs_tb.sv
// Purpose: self-checking bench for the radio status register bank
// Assumes: read data valid only in the cycle after the read strobe
// Notes:   status inputs held steady except state field and checksum flag; bank read-only
module rsr_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsr_pkg::*;
	logic              clk_sys_i = 1'b0;
	logic              rst_n_i   = 1'b0;
	logic [5:0]        addr_i    = 6'h00;
	logic [7:0]        wdata_i   = 8'h00;
	logic              wr_i      = 1'b0;
	logic              rd_i      = 1'b0;
	logic              amplitude_keying_i = 1'b0;
	rsr_status_t       status_i  = {8'h9c, 7'h2b, 1'b1, 8'hd3, 5'h13, 16'hbe71, 8'h6e};
	rsr_pins_t         pins_i    = 6'b101011;
	logic [7:0]        rdata_o;
	int                error_cnt = 0;
	int                samples_checked = 0;
	logic [5:0]        row_addr [12] = '{6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3a, 6'h00};
	logic [7:0]        row_exp  [12] = '{8'h5a, 8'ha5, 8'h9c, 8'hab, 8'hd3, 8'h13, 8'hbe, 8'h71, 8'hd5, 8'h6e, 8'h00, 8'h00};
	always #12.5 clk_sys_i = ~clk_sys_i;
	rsr_status_regs i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .amplitude_keying_i(amplitude_keying_i), .status_i(status_i), .pins_i(pins_i), .rdata_o(rdata_o));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic stop_test;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Data checked in the one cycle it stands
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i   <= 1'b0;
		@(negedge clk_sys_i);
		chk(rdata_o, e);
	endtask : rd_chk
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_i);
		chk(rdata_o, 8'h00);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			rd_chk(row_addr[i], row_exp[i]);
		end
		@(negedge clk_sys_i);
		chk(rdata_o, 8'h00);
		// Sleep and crystal-off codes 0 and 2 never show: the access itself wakes it
		for (int s = 0; s <= 22; s++) begin
			@(posedge clk_sys_i);
			status_i.radio_state_field <= s[4:0];
			rd_chk(6'h35, (s == 0 || s == 2) ? 8'h01 : {3'h0, s[4:0]});
		end
		@(posedge clk_sys_i);
		amplitude_keying_i         <= 1'b1;
		status_i.crc_match         <= 1'b0;
		rd_chk(6'h32, 8'h00);
		rd_chk(6'h33, 8'h2b);
		rd_chk(6'h38, 8'h55);
		@(posedge clk_sys_i);
		wr_i    <= 1'b1;
		addr_i  <= 6'h34;
		wdata_i <= 8'hff;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
		@(negedge clk_sys_i);
		chk(rdata_o, 8'h00);
		rd_chk(6'h34, 8'hd3);
		stop_test();
	end
endmodule : rsr_status_regs_tb
